// >>> hw/rtc_pkg.sv
// Shared constants, register map and types of the receive-port timestamp capture block.
`default_nettype none

package rtc_pkg;

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int CLK_PERIOD_NS = 5;
    localparam int TICK_RES0_NS  = 40;
    localparam int TICK_RES1_NS  = 80;
    localparam int TICK_RES2_NS  = 160;
    localparam int TICK_RES3_NS  = 1000;
    localparam logic [7:0] TICK_RES0_CYC = 8'(TICK_RES0_NS / CLK_PERIOD_NS);
    localparam logic [7:0] TICK_RES1_CYC = 8'(TICK_RES1_NS / CLK_PERIOD_NS);
    localparam logic [7:0] TICK_RES2_CYC = 8'(TICK_RES2_NS / CLK_PERIOD_NS);
    localparam logic [7:0] TICK_RES3_CYC = 8'(TICK_RES3_NS / CLK_PERIOD_NS);
    // The counter runs over 65535 ticks, so its last value is one below that.
    localparam logic [15:0] STAMP_LAST   = 16'hFFFE;

    // ==========================================================
    // Register indices (byte address is four times the index)
    // ==========================================================
    localparam logic [7:0] IDX_CONFIG   = 8'h25;
    localparam logic [7:0] IDX_CONTROL  = 8'h26;
    localparam logic [7:0] IDX_LINE_HI  = 8'h27;
    localparam logic [7:0] IDX_LINE_LO  = 8'h28;
    localparam logic [7:0] IDX_STATUS   = 8'h29;
    localparam logic [7:0] IDX_P0_HI    = 8'h2A;
    localparam logic [7:0] IDX_P0_LO    = 8'h2B;
    localparam logic [7:0] IDX_P1_HI    = 8'h2C;
    localparam logic [7:0] IDX_P1_LO    = 8'h2D;

    // ==========================================================
    // Field positions and reset values
    // ==========================================================
    localparam int CFG_EDGE_BIT  = 6;
    localparam int CFG_RES_LSB   = 4;
    localparam int CFG_AVAIL_BIT = 3;
    localparam int CFG_FREE_BIT  = 1;
    localparam int CFG_MODE_BIT  = 0;
    localparam int CTL_HOLD_BIT  = 4;
    localparam int CTL_EN1_BIT   = 1;
    localparam int CTL_EN0_BIT   = 0;
    localparam int STS_READY_BIT = 4;
    localparam int STS_VAL1_BIT  = 1;
    localparam int STS_VAL0_BIT  = 0;
    localparam logic [7:0]  CONFIG_RESET  = 8'h00;
    localparam logic [7:0]  CONTROL_RESET = 8'h00;
    localparam logic [15:0] LINE_RESET    = 16'h0000;

    // ==========================================================
    // Types
    // ==========================================================
    typedef struct packed {
        logic       sync_edge_select;
        logic [1:0] tick_resolution_select;
        logic       ready_when_all_available;
        logic       free_running_select;
        logic       capture_event_select;
    } rtc_cfg_t;

    typedef struct packed {
        logic frame_start;
        logic line_start;
    } rtc_video_t;

    typedef enum {ST_SEEK, ST_ARMED} rtc_arm_t;

    function automatic logic [7:0] tick_period(input logic [1:0] sel);
        case (sel)
            2'b00:   tick_period = TICK_RES0_CYC;
            2'b01:   tick_period = TICK_RES1_CYC;
            2'b10:   tick_period = TICK_RES2_CYC;
            default: tick_period = TICK_RES3_CYC;
        endcase
    endfunction

endpackage

`default_nettype wire

// >>> hw/rtc_tick_counter.sv
// Timestamp counter with selectable tick period and frame-sync restart.
`default_nettype none

module rtc_tick_counter (
    input  wire logic        clk,     // Clock.
    input  wire logic        rst_n,   // Async reset, low.
    input  wire logic [1:0]  res_sel, // Tick resolution code.
    input  wire logic        restart, // Clears prescaler and counter.
    output logic      [15:0] stamp,   // Current count.
    output logic             tick,    // One-cycle tick pulse.
    output logic             wrap     // Tick on which the count wraps.
);
    import rtc_pkg::*;

    logic [7:0]  pre_q;
    logic [15:0] stamp_q;
    logic [7:0]  last_pre;

    // ==========================================================
    // Prescaler
    // ==========================================================
    // A compare with >= keeps the prescaler sane when the code shrinks mid-count.
    assign last_pre = 8'(tick_period(res_sel) - 8'd1);
    assign tick     = !restart && (pre_q >= last_pre);
    assign wrap     = tick && (stamp_q == STAMP_LAST);
    assign stamp    = stamp_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_q <= 8'h00;
        end else if (restart || tick) begin
            pre_q <= 8'h00;
        end else begin
            pre_q <= 8'(pre_q + 8'd1);
        end
    end

    // ==========================================================
    // Counter
    // ==========================================================
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stamp_q <= 16'h0000;
        end else if (restart || wrap) begin
            stamp_q <= 16'h0000;
        end else if (tick) begin
            stamp_q <= 16'(stamp_q + 16'd1);
        end
    end

    AST_TICK_40NS: assert property (@(posedge clk) disable iff (!rst_n)
        tick ##1 (!restart && res_sel == 2'b00)[*8] |-> tick)
        else $error("tick period at 40 ns code is not 8 cycles");

    AST_STAMP_WRAP: assert property (@(posedge clk) disable iff (!rst_n)
        (tick && stamp_q == STAMP_LAST) |=> (stamp_q == 16'h0000))
        else $error("counter did not wrap after 65535 ticks");

    AST_STAMP_STEP: assert property (@(posedge clk) disable iff (!rst_n)
        (tick && stamp_q != STAMP_LAST) |=> (stamp_q == 16'($past(stamp_q) + 16'd1)))
        else $error("counter did not advance by one on a tick");

endmodule

`default_nettype wire

// >>> hw/rtc_port_capture.sv
// Per-receive-port line counting and timestamp capture.
`default_nettype none

module rtc_port_capture (
    input  wire logic                clk,       // Clock.
    input  wire logic                rst_n,     // Async reset, low.
    input  wire rtc_pkg::rtc_video_t video,     // Frame and line start pulses.
    input  wire logic                enable,    // Port takes part in capture.
    input  wire logic                hold,      // Freeze captured value.
    input  wire logic                frame_mode, // 1 captures at frame start.
    input  wire logic                free_run,  // Free-running reference.
    input  wire logic         [15:0] line_num,  // Programmed line.
    input  wire logic         [15:0] stamp,     // Live counter.
    output logic              [15:0] captured,  // Captured timestamp.
    output logic                     valid      // Captured value is valid.
);
    import rtc_pkg::*;

    logic [15:0] line_cnt_q;
    logic [15:0] line_next;
    logic [15:0] cap_q;
    logic        valid_q;
    logic        line_hit;
    logic        cap_evt;
    logic        cap;
    rtc_arm_t    state_q;

    assign line_next = 16'(line_cnt_q + 16'd1);
    assign line_hit  = video.line_start && (line_next == line_num);
    assign captured  = cap_q;
    assign valid     = valid_q;

    always_comb begin
        if (!frame_mode) begin
            cap_evt = line_hit;
        end else if (!free_run) begin
            cap_evt = video.frame_start;
        end else begin
            cap_evt = (state_q == ST_ARMED) && video.frame_start;
        end
    end

    assign cap = cap_evt && enable && !hold;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            line_cnt_q <= 16'h0000;
        end else if (video.frame_start) begin
            line_cnt_q <= 16'h0000;
        end else if (video.line_start) begin
            line_cnt_q <= line_next;
        end
    end

    // Free-running frame mode waits for the programmed line before it looks for a frame start.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_SEEK;
        end else if (!frame_mode || !free_run || !enable) begin
            state_q <= ST_SEEK;
        end else begin
            case (state_q)
                ST_SEEK: begin
                    if (line_hit) begin
                        state_q <= ST_ARMED;
                    end
                end
                ST_ARMED: begin
                    if (cap) begin
                        state_q <= ST_SEEK;
                    end
                end
                default: state_q <= ST_SEEK;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cap_q <= 16'h0000;
        end else if (cap) begin
            cap_q <= stamp;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            valid_q <= 1'b0;
        end else if (!enable) begin
            valid_q <= 1'b0;
        end else if (cap) begin
            valid_q <= 1'b1;
        end
    end

    AST_LINE_CAPTURE: assert property (@(posedge clk) disable iff (!rst_n)
        (!frame_mode && line_hit && enable && !hold)
        |=> (valid_q && cap_q == $past(stamp)))
        else $error("line-start capture missed");

    AST_HOLD_STABLE: assert property (@(posedge clk) disable iff (!rst_n)
        hold |=> $stable(cap_q))
        else $error("captured value changed while frozen");

    AST_DISABLED_INVALID: assert property (@(posedge clk) disable iff (!rst_n)
        !enable |=> !valid_q)
        else $error("disabled port shows a valid timestamp");

    AST_FREE_SEEK: assert property (@(posedge clk) disable iff (!rst_n)
        (frame_mode && free_run && state_q == ST_SEEK) |-> !cap)
        else $error("free-running frame capture before programmed line");

endmodule

`default_nettype wire

// >>> hw/rtc_top.sv
// Receive-port timestamp capture block with its AHB-Lite register slave.
//
// Our own choice: the AHB-Lite interface to the registers.
`default_nettype none

// Overview of operation
// - The sync edge select picks the rising frame-sync edge at 0 and the falling edge at 1.
// - The timestamp counter runs over 65535 ticks before it wraps to zero.
// - With the ready control set, ready rises as soon as every enabled port has a stamp.
// - The free-run bit picks frame-sync reference at 0 and free-running reference at 1.
// - The capture event bit captures at a line start at 0 and at a frame start at 1.
// - Writing the hold bit as 1 freezes all stamps and clears ready at once; 0 resumes.
// - Each receive port has its own enable and only an enabled port captures.
// - In line mode the programmed 16-bit line number sets the line that is captured.
// - In free-running frame mode the line number sets when frame-start checking begins.
// - Read-only flags report ready and a valid stamp for each receive port.
// - Each port's 16-bit stamp reads as a high byte and a low byte.

module rtc_top (
    input  wire logic                hclk,       // Bus and block clock.
    input  wire logic                hresetn,    // Async reset, low.
    input  wire logic                hsel,       // Slave select.
    input  wire logic         [31:0] haddr,      // Byte address.
    input  wire logic         [1:0]  htrans,     // Transfer type.
    input  wire logic                hwrite,     // Write when high.
    input  wire logic         [2:0]  hsize,      // Transfer size.
    input  wire logic                hready,     // Bus ready.
    input  wire logic         [31:0] hwdata,     // Write data.
    output logic              [31:0] hrdata,     // Read data.
    output logic                     hreadyout,  // Slave ready.
    output logic                     hresp,      // Response, always OKAY.
    input  wire logic                frame_sync, // Frame synchronisation level.
    input  wire rtc_pkg::rtc_video_t rx0_video,  // Port 0 frame and line starts.
    input  wire rtc_pkg::rtc_video_t rx1_video   // Port 1 frame and line starts.
);
    import rtc_pkg::*;

    // ==========================================================
    // Declarations
    // ==========================================================
    rtc_cfg_t    cfg_q;
    logic        hold_q;
    logic [1:0]  en_q;
    logic [15:0] line_q;
    logic        ready_q;
    logic        sync_prev_q;
    logic        wr_pend_q;
    logic [7:0]  wr_idx_q;
    logic [31:0] hrdata_q;
    logic        hreadyout_q;

    logic        acc;
    logic        rd_acc;
    logic        wr_en;
    logic        freeze_set;
    logic [7:0]  rd_byte;
    logic        fs_edge;
    logic        restart;
    logic [15:0] stamp;
    logic        wrap;
    logic        ref_event;
    logic        all_avail;
    logic        ready_set;
    logic [1:0]  valid;
    logic [15:0] cap [2];
    rtc_video_t  video [2];

    // ==========================================================
    // Address decode
    // ==========================================================
    function automatic logic [7:0] reg_index(input logic [31:0] a);
        reg_index = a[9:2];
    endfunction

    function automatic logic is_mapped(input logic [31:0] a);
        logic [7:0] i;
        i = reg_index(a);
        is_mapped = (a[31:10] == 22'h00_0000) && (a[1:0] == 2'b00)
                    && (i >= IDX_CONFIG) && (i <= IDX_P1_LO);
    endfunction

    assign acc    = hsel && hready && htrans[1];
    assign rd_acc = acc && !hwrite;
    assign wr_en  = wr_pend_q;

    // Writing a 1 to the hold bit clears ready even when the bit is already set.
    assign freeze_set = wr_en && (wr_idx_q == IDX_CONTROL)
                        && hwdata[CTL_HOLD_BIT];

    // ==========================================================
    // Bus slave
    // ==========================================================
    // Every transfer completes with no wait state and an OKAY answer.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout_q <= 1'b1;
        end else begin
            hreadyout_q <= 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_idx_q  <= 8'h00;
        end else begin
            wr_pend_q <= acc && hwrite && is_mapped(haddr);
            wr_idx_q  <= reg_index(haddr);
        end
    end

    // Read data are taken from the address phase, so a read placed right behind a
    // write sees the older register value; the single-transfer master never does that.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= 32'h0000_0000;
        end else if (rd_acc && is_mapped(haddr)) begin
            hrdata_q <= {24'h00_0000, rd_byte};
        end else begin
            hrdata_q <= 32'h0000_0000;
        end
    end

    always_comb begin
        rd_byte = 8'h00;
        case (reg_index(haddr))
            IDX_CONFIG: begin
                rd_byte[CFG_EDGE_BIT]                   = cfg_q.sync_edge_select;
                rd_byte[CFG_RES_LSB +: 2]               = cfg_q.tick_resolution_select;
                rd_byte[CFG_AVAIL_BIT]                  = cfg_q.ready_when_all_available;
                rd_byte[CFG_FREE_BIT]                   = cfg_q.free_running_select;
                rd_byte[CFG_MODE_BIT]                   = cfg_q.capture_event_select;
            end
            IDX_CONTROL: begin
                rd_byte[CTL_HOLD_BIT] = hold_q;
                rd_byte[CTL_EN1_BIT]  = en_q[1];
                rd_byte[CTL_EN0_BIT]  = en_q[0];
            end
            IDX_LINE_HI: rd_byte = line_q[15:8];
            IDX_LINE_LO: rd_byte = line_q[7:0];
            IDX_STATUS: begin
                rd_byte[STS_READY_BIT] = ready_q;
                rd_byte[STS_VAL1_BIT]  = valid[1];
                rd_byte[STS_VAL0_BIT]  = valid[0];
            end
            IDX_P0_HI: rd_byte = cap[0][15:8];
            IDX_P0_LO: rd_byte = cap[0][7:0];
            IDX_P1_HI: rd_byte = cap[1][15:8];
            IDX_P1_LO: rd_byte = cap[1][7:0];
            default:   rd_byte = 8'h00;
        endcase
    end

    assign hrdata    = hrdata_q;
    assign hreadyout = hreadyout_q;
    assign hresp     = 1'b0;

    // ==========================================================
    // Configuration and control registers
    // ==========================================================
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_q <= rtc_cfg_t'(CONFIG_RESET);
        end else if (wr_en && wr_idx_q == IDX_CONFIG) begin
            cfg_q.sync_edge_select         <= hwdata[CFG_EDGE_BIT];
            cfg_q.tick_resolution_select   <= hwdata[CFG_RES_LSB +: 2];
            cfg_q.ready_when_all_available <= hwdata[CFG_AVAIL_BIT];
            cfg_q.free_running_select      <= hwdata[CFG_FREE_BIT];
            cfg_q.capture_event_select     <= hwdata[CFG_MODE_BIT];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hold_q <= CONTROL_RESET[CTL_HOLD_BIT];
            en_q   <= CONTROL_RESET[CTL_EN1_BIT:CTL_EN0_BIT];
        end else if (wr_en && wr_idx_q == IDX_CONTROL) begin
            hold_q <= hwdata[CTL_HOLD_BIT];
            en_q   <= hwdata[CTL_EN1_BIT:CTL_EN0_BIT];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            line_q <= LINE_RESET;
        end else if (wr_en && wr_idx_q == IDX_LINE_HI) begin
            line_q[15:8] <= hwdata[7:0];
        end else if (wr_en && wr_idx_q == IDX_LINE_LO) begin
            line_q[7:0] <= hwdata[7:0];
        end
    end

    // ==========================================================
    // Frame sync and counter
    // ==========================================================
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync_prev_q <= 1'b0;
        end else begin
            sync_prev_q <= frame_sync;
        end
    end

    assign fs_edge = cfg_q.sync_edge_select ? (sync_prev_q && !frame_sync)
                                            : (!sync_prev_q && frame_sync);
    assign restart = fs_edge && !cfg_q.free_running_select;

    rtc_tick_counter u_tick (
        .clk     (hclk),
        .rst_n   (hresetn),
        .res_sel (cfg_q.tick_resolution_select),
        .restart (restart),
        .stamp   (stamp),
        .tick    (),
        .wrap    (wrap)
    );

    // ==========================================================
    // Receive ports
    // ==========================================================
    assign video[0] = rx0_video;
    assign video[1] = rx1_video;

    for (genvar p = 0; p < 2; p++) begin : g_port
        rtc_port_capture u_cap (
            .clk        (hclk),
            .rst_n      (hresetn),
            .video      (video[p]),
            .enable     (en_q[p]),
            .hold       (hold_q),
            .frame_mode (cfg_q.capture_event_select),
            .free_run   (cfg_q.free_running_select),
            .line_num   (line_q),
            .stamp      (stamp),
            .captured   (cap[p]),
            .valid      (valid[p])
        );
    end

    // ==========================================================
    // Ready flag
    // ==========================================================
    // Normal ready waits for the next reference event so that all stamps of a
    // frame are reported together; the early option trades that for latency.
    assign all_avail = (en_q != 2'b00) && ((valid & en_q) == en_q);
    assign ref_event = cfg_q.free_running_select ? wrap : fs_edge;
    assign ready_set = cfg_q.ready_when_all_available || ref_event;

    // The freeze write is documented to clear ready, so it beats a set in the same cycle.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ready_q <= 1'b0;
        end else if (freeze_set || !all_avail) begin
            ready_q <= 1'b0;
        end else if (!hold_q && ready_set) begin
            ready_q <= 1'b1;
        end
    end

    // ==========================================================
    // Checks
    // ==========================================================
    AST_FREEZE_CLEARS_READY: assert property (@(posedge hclk) disable iff (!hresetn)
        freeze_set |=> !ready_q)
        else $error("ready stayed set after freeze write");

    AST_READY_NEEDS_ALL: assert property (@(posedge hclk) disable iff (!hresetn)
        !all_avail |=> !ready_q)
        else $error("ready set while an enabled port lacks a stamp");

    AST_READY_AS_AVAIL: assert property (@(posedge hclk) disable iff (!hresetn)
        (cfg_q.ready_when_all_available && all_avail && !hold_q && !freeze_set)
        |=> ready_q)
        else $error("early ready not raised when all stamps available");

    AST_SYNC_RESTART: assert property (@(posedge hclk) disable iff (!hresetn)
        (!cfg_q.free_running_select && !cfg_q.sync_edge_select
         && !sync_prev_q && frame_sync) |=> (stamp == 16'h0000))
        else $error("rising frame-sync edge did not restart the counter");

    AST_STATUS_READ: assert property (@(posedge hclk) disable iff (!hresetn)
        (rd_acc && haddr == {22'h00_0000, IDX_STATUS, 2'b00})
        |=> (hrdata_q[STS_READY_BIT] == $past(ready_q)
             && hrdata_q[STS_VAL1_BIT:STS_VAL0_BIT] == $past(valid)))
        else $error("status read does not show ready and valid flags");

endmodule

`default_nettype wire

// >>> tb/rtc_top_test.sv
// Self-checking bench of the receive-port timestamp capture block.
`default_nettype none
module rtc_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    import rtc_pkg::*;
    // ==========================================================
    // Stimulus and design
    // ==========================================================
    logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, fs = 0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
    logic [1:0]  htrans = '0;
    logic [2:0]  hsize = 3'h2;
    logic        hreadyout, hresp;
    rtc_video_t  vid = '0;
    int          n_mismatch = 0, n_compared = 0, seed = 56, p;
    logic [15:0] st, ln;
    always #2.5 hclk = ~hclk;
    rtc_top u_rtc_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .frame_sync(fs), .rx0_video(vid), .rx1_video(vid));
    // ==========================================================
    // Tasks
    // ==========================================================
    task automatic finish_test;
        if (n_mismatch == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One single transfer; the answer is awaited, never assumed.
    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {22'h0, idx, 2'b00};
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h0, d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        chk(32'(hresp), 32'h0);
    endtask
    task automatic rd_p0;
        bus(1'b0, IDX_P0_HI, 8'h00);
        st[15:8] = rd[7:0];
        bus(1'b0, IDX_P0_LO, 8'h00);
        st[7:0] = rd[7:0];
    endtask
    task automatic vpulse(input logic [1:0] v);
        @(posedge hclk) vid <= v;
        @(posedge hclk) vid <= '0;
    endtask
    function automatic int tick_cyc(input int c);
        return (c == 3) ? 200 : 8 << c;
    endfunction
    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        repeat (50000) @(posedge hclk);
        n_mismatch++;
        finish_test;
    end
    initial begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        for (int i = 'h25; i <= 'h2D; i++) begin
            bus(1'b0, 8'(i), 8'h00);
            chk(rd, 32'h0);
        end
        repeat (4) begin
            ln = 16'($random(seed));
            bus(1'b1, IDX_CONFIG, ln[7:0]);
            bus(1'b0, IDX_CONFIG, 8'h00);
            chk(rd, {24'h0, ln[7:0] & 8'h7B});
        end
        bus(1'b1, IDX_STATUS, 8'hFF);
        bus(1'b0, IDX_STATUS, 8'h00);
        chk(rd, 32'h0);
        bus(1'b0, 8'h40, 8'h00);
        chk(rd, 32'h0);
        bus(1'b1, IDX_CONTROL, 8'h03);
        for (int c = 0; c < 4; c++) begin
            p = tick_cyc(c);
            ln = 16'($unsigned($random(seed)) % 4 + 2);
            bus(1'b1, IDX_LINE_LO, ln[7:0]);
            bus(1'b1, IDX_CONFIG, {1'b0, c[0], c[1:0], 4'h0});
            fs <= c[0];
            repeat (3 * p) @(posedge hclk);
            fs <= ~c[0];
            vpulse(2'b10);
            repeat (5 * p - 2 - 2 * ln) @(posedge hclk);
            repeat (ln) vpulse(2'b01);
            rd_p0();
            chk(st, 32'((5 * p - 2) / p));
            bus(1'b0, IDX_P1_LO, 8'h00);
            chk(rd[7:0], st[7:0]);
            bus(1'b0, IDX_STATUS, 8'h00);
            chk(rd[1:0], 2'b11);
        end
        bus(1'b1, IDX_CONTROL, 8'h13);
        bus(1'b0, IDX_STATUS, 8'h00);
        chk(rd, 32'h03);
        vpulse(2'b10);
        repeat (ln) vpulse(2'b01);
        bus(1'b0, IDX_P0_LO, 8'h00);
        chk(rd[7:0], st[7:0]);
        bus(1'b1, IDX_CONTROL, 8'h03);
        bus(1'b1, IDX_CONFIG, 8'h38);
        repeat (4) @(posedge hclk);
        bus(1'b0, IDX_STATUS, 8'h00);
        chk(rd, 32'h13);
        ln = st;
        bus(1'b1, IDX_CONFIG, 8'h01);
        vpulse(2'b10);
        rd_p0();
        chk(st != ln, 1);
        ln = st;
        bus(1'b1, IDX_CONFIG, 8'h03);
        bus(1'b1, IDX_LINE_LO, 8'h02);
        vpulse(2'b10);
        rd_p0();
        chk(st, ln);
        repeat (2) vpulse(2'b01);
        vpulse(2'b10);
        rd_p0();
        chk(st != ln, 1);
        bus(1'b1, IDX_CONTROL, 8'h01);
        bus(1'b0, IDX_STATUS, 8'h00);
        chk(rd, 32'h11);
        bus(1'b1, IDX_CONTROL, 8'h00);
        bus(1'b0, IDX_STATUS, 8'h00);
        chk(rd, 32'h0);
        finish_test;
    end
endmodule
`default_nettype wire
